/* src/rct_top.sv */
// Channel timing: transmit on the line timing clock, receive with clock recovery
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Transmit line shifter is clocked only by the one external line timing clock; the transmit buffer runs on MCLK.
// - Receive data decoded as NRZI-mark, no receive clock from far end.
// - Receive bit clock recovered by a loop running at sixteen times bit rate.
// - Recovered clock is driven out as the serial controller receive clock.
// - Link runs at 64K baud in the combined variant.
// - This logic serves channel 1 (RS422); channel 2 is fiber elsewhere.
// - Receive rate is fixed at 64 kbps, no rate setting affects it; transmit rate follows the line timing clock.
module rct_top
  import rct_pkg::*;
#(
  parameter int WORD_W     = 8,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic              LINE_TX_CLK,
  output logic                   TXD,
  input  wire logic [WORD_W-1:0] TX_WORD,
  input  wire logic              TX_VALID,
  output logic                   TX_READY,
  input  wire logic              RXD,
  output logic                   RX_CLK,
  output logic                   RX_BIT,
  output logic                   RX_BIT_VALID
);
  localparam int BW = $clog2(WORD_W);

  if (WORD_W < 2 || WORD_W > 32) begin : g_bad_width
    $error("rct_top: WORD_W must lie between 2 and 32");
  end

  // ==========================================================================
  // Transmit buffer in the system clock domain
  logic [WORD_W-1:0] f_data;
  logic              f_valid, f_ready, f_in_ready;
  logic              ready_reg, ready_next;

  rct_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (MCLK),
    .rst       (RESET),
    .in_data   (TX_WORD),
    .in_valid  (TX_VALID && ready_reg),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // ==========================================================================
  // Word handover to the line clock domain (toggle request / toggle ack)
  logic              req_s1_reg, req_s2_reg;
  logic              req_tgl_reg, req_tgl_next;
  logic              ack_reg, ack_next;
  logic [WORD_W-1:0] hold_reg, hold_next;

  always_comb begin
    f_ready    = (req_s2_reg != ack_reg) && f_valid;
    ack_next   = f_ready ? ~ack_reg : ack_reg;
    hold_next  = f_ready ? f_data : hold_reg;
    // Registered ready: may lag one cycle, so it is gated into the push
    ready_next = f_in_ready && !(TX_VALID && ready_reg);
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_reg    <= 1'b0;
      hold_reg   <= WORD_W'(IDLE_WORD);
      ready_reg  <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      ack_reg    <= ack_next;
      hold_reg   <= hold_next;
      ready_reg  <= ready_next;
    end
  end
  assign TX_READY = ready_reg;

  a_ack_follows: assert property (@(posedge MCLK) disable iff (RESET)
    f_ready |=> ack_reg != $past(ack_reg) && hold_reg == $past(f_data))
    else $error("handover word not latched with ack");

  // ==========================================================================
  // Line side: everything runs on the falling edge of the far-end timing
  // clock, so data settles half a bit before the far end's rising edge.
  // The clock may stop; a word in the shifter then holds mid-shift until edges resume.
  logic              lrst_s1_reg, lrst_reg;
  logic              ack_s1_reg, ack_s2_reg;
  logic [WORD_W-1:0] sh_reg, sh_next;
  logic [BW-1:0]     bit_reg, bit_next;
  logic              txd_reg, txd_next;

  always_comb begin
    sh_next      = {sh_reg[WORD_W-2:0], 1'b0};
    bit_next     = bit_reg + 1'b1;
    req_tgl_next = req_tgl_reg;
    txd_next     = sh_reg[WORD_W-1];
    if (bit_reg == BW'(WORD_W - 1)) begin
      bit_next = '0;
      if (ack_s2_reg == req_tgl_reg) begin
        sh_next      = hold_reg;
        req_tgl_next = ~req_tgl_reg;
      end else begin
        sh_next = WORD_W'(IDLE_WORD);
      end
    end
  end

  always_ff @(negedge LINE_TX_CLK) begin
    lrst_s1_reg <= RESET;
    lrst_reg    <= lrst_s1_reg;
    ack_s1_reg  <= ack_reg;
    ack_s2_reg  <= ack_s1_reg;
  end

  always_ff @(negedge LINE_TX_CLK) begin
    if (lrst_reg) begin
      req_tgl_reg <= 1'b0;
      sh_reg      <= WORD_W'(TX_RST_VAL);
      bit_reg     <= '0;
      txd_reg     <= 1'b1;
    end else begin
      req_tgl_reg <= req_tgl_next;
      sh_reg      <= sh_next;
      bit_reg     <= bit_next;
      txd_reg     <= txd_next;
    end
  end
  assign TXD = txd_reg;

  a_tx_msb_out: assert property (@(negedge LINE_TX_CLK) disable iff (lrst_reg)
    1'b1 |=> TXD == $past(sh_reg[WORD_W-1]))
    else $error("line bit not taken from shifter top");
  a_tx_load: assert property (@(negedge LINE_TX_CLK) disable iff (lrst_reg)
    bit_reg == BW'(WORD_W - 1) && ack_s2_reg == req_tgl_reg
    |=> sh_reg == $past(hold_reg) && req_tgl_reg != $past(req_tgl_reg))
    else $error("handed word not loaded at word boundary");

  // ==========================================================================
  // Oversampling tick at sixteen times the fixed bit rate
  logic [NCO_BITS-1:0] nco_reg, nco_next;
  logic                tick_reg, tick_next;

  always_comb begin
    {tick_next, nco_next} = {1'b0, nco_reg} + {1'b0, NCO_STEP};
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      nco_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      nco_reg  <= nco_next;
      tick_reg <= tick_next;
    end
  end

  a_tick_rate: assert property (@(posedge MCLK) disable iff (RESET)
    tick_reg |=> !tick_reg ##[38:39] tick_reg)
    else $error("oversampling tick spacing wrong");

  // ==========================================================================
  // Receive: synchroniser, edge detect, clock recovery and decode
  logic       rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic       edge_reg, edge_next;
  logic [3:0] ph_reg, ph_next;
  logic       last_reg, last_next;
  logic       sample;
  logic       rxclk_reg, rxclk_next;
  logic       rbit_reg, rbit_next;
  logic       rval_reg, rval_next;
  logic       line_edge;

  always_comb begin
    line_edge = rx_s2_reg != rx_s3_reg;
    edge_next = edge_reg || line_edge;
    ph_next   = ph_reg;
    if (tick_reg) begin
      edge_next = line_edge;
      // Edges belong at phase 0: early half retards, late half advances
      if (!edge_reg || ph_reg == PH_RESET) begin
        ph_next = ph_reg + 4'h1;
      end else if (ph_reg < PH_SAMPLE) begin
        ph_next = ph_reg;
      end else begin
        ph_next = ph_reg + 4'h2;
      end
    end
    sample     = tick_reg && ph_reg == PH_BEFORE && ph_next == PH_SAMPLE;
    last_next  = sample ? rx_s2_reg : last_reg;
    rbit_next  = sample ? (rx_s2_reg ^ last_reg) : rbit_reg;
    rval_next  = sample;
    // Rising edge at phase 0, mid-way through the decoded bit's hold time
    rxclk_next = tick_reg ? ~ph_next[3] : rxclk_reg;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      // Synchroniser keeps following the line, so release shows no false edge
      rx_s1_reg <= RXD;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      edge_reg  <= 1'b0;
      ph_reg    <= PH_RESET;
      last_reg  <= rx_s2_reg;
      rxclk_reg <= 1'b0;
      rbit_reg  <= 1'b0;
      rval_reg  <= 1'b0;
    end else begin
      rx_s1_reg <= RXD;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      edge_reg  <= edge_next;
      ph_reg    <= ph_next;
      last_reg  <= last_next;
      rxclk_reg <= rxclk_next;
      rbit_reg  <= rbit_next;
      rval_reg  <= rval_next;
    end
  end

  assign RX_CLK       = rxclk_reg;
  assign RX_BIT       = rbit_reg;
  assign RX_BIT_VALID = rval_reg;

  sequence s_sample_seen;
    tick_reg && ph_reg == PH_BEFORE && !edge_reg;
  endsequence
  sequence s_bit_out;
    ##1 rval_reg && RX_BIT == ($past(rx_s2_reg) ^ $past(last_reg));
  endsequence

  a_decode_change: assert property (@(posedge MCLK) disable iff (RESET)
    s_sample_seen |-> s_bit_out)
    else $error("decoded bit not equal to level change");
  a_valid_pulse: assert property (@(posedge MCLK) disable iff (RESET)
    rval_reg |=> !rval_reg)
    else $error("bit valid longer than one cycle");
  a_phase_step: assert property (@(posedge MCLK) disable iff (RESET)
    tick_reg && !edge_reg |=> ph_reg == $past(ph_reg) + 4'h1)
    else $error("phase did not advance by one");
  a_phase_hold: assert property (@(posedge MCLK) disable iff (RESET)
    !tick_reg |=> ph_reg == $past(ph_reg))
    else $error("phase moved without tick");
  a_clk_rise: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(RX_CLK) |-> ph_reg[3] == 1'b0 && $past(tick_reg))
    else $error("recovered clock rose off phase");
endmodule
`default_nettype wire

/* src/rct_pkg.sv */
// Shared constants for the RS422 channel timing block
package rct_pkg;
  // ==========================================================================
  // Rates
  localparam int unsigned MCLK_HZ     = 40_000_000;
  localparam int unsigned BIT_RATE_HZ = 64_000;
  localparam int unsigned OVERSAMPLE  = 16;
  // ==========================================================================
  // Oversampling tick generator: phase accumulator, no integer divide exists
  localparam int unsigned NCO_BITS = 24;
  localparam logic [63:0] NCO_STEP64 =
    ((64'(BIT_RATE_HZ) * 64'(OVERSAMPLE)) << NCO_BITS) / 64'(MCLK_HZ);
  localparam logic [23:0] NCO_STEP = NCO_STEP64[23:0];
  // ==========================================================================
  // Clock recovery phase positions
  localparam logic [3:0] PH_RESET  = 4'h0;
  localparam logic [3:0] PH_SAMPLE = 4'h8;
  localparam logic [3:0] PH_BEFORE = 4'h7;
  // ==========================================================================
  // Transmit defaults
  localparam logic [7:0] IDLE_WORD  = 8'hFF;
  localparam logic [7:0] TX_RST_VAL = 8'hFF;
endpackage

/* src/rct_fifo.sv */
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rct_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rct_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             push, pop;

  // ==========================================================================
  // Pointers and fill level
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage carries no reset so it can map onto memory
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];

  // ==========================================================================
  // Checks
  a_full_stalls: assert property (@(posedge clk) disable iff (rst)
    cnt_reg == CW'(DEPTH) && in_valid |=> wr_reg == $past(wr_reg))
    else $error("fifo accepts while full");
  a_fill_count: assert property (@(posedge clk) disable iff (rst)
    push && !pop |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("fifo count did not rise on push");
endmodule
`default_nettype wire

/* tb/rct_mux_model.sv */
// Far-end multiplexer model: sources link timing, samples TXD, sends NRZI-mark data
`timescale 1ns/1ps
`default_nettype none
module rct_mux_model (
  input  wire logic stall,
  input  wire logic capture,
  input  wire logic TXD,
  output logic      LINE_TX_CLK,
  output logic      RXD
);
  logic tx_bits[$];
  logic rx_bits[$];
  // ==========================================================================
  // Link clock: free running stream, parked low while stalled
  initial begin
    // Start high so time zero shows no falling edge to the link logic
    LINE_TX_CLK = 1'h1;
    #37;
    forever begin
      #80;
      if (!stall || LINE_TX_CLK) LINE_TX_CLK = ~LINE_TX_CLK;
    end
  end
  // Rising edge falls in the middle of each bit
  always @(posedge LINE_TX_CLK) if (capture) tx_bits.push_back(TXD);
  // ==========================================================================
  // Receive line: a mark is a level change, an empty queue keeps the level
  initial begin
    RXD = 1'h1;
    #5;
    forever begin
      #15625;
      if (rx_bits.size() > 0 && rx_bits.pop_front()) RXD = ~RXD;
    end
  end
endmodule
`default_nettype wire

/* tb/rct_top_tb.sv */
// Self-checking bench for the channel timing block
`timescale 1ns/1ps
`default_nettype none
module rct_top_tb;
  import rct_pkg::*;
  localparam int WORD_W     = 8;
  localparam int FIFO_DEPTH = 16;
  logic              MCLK, RESET, LINE_TX_CLK, TXD, TX_VALID, TX_READY;
  logic              RXD, RX_CLK, RX_BIT, RX_BIT_VALID, stall, capture;
  logic [WORD_W-1:0] TX_WORD;
  logic              rx_seen[$];
  int                n_mismatch, total_checks;

  rct_top #(.WORD_W(WORD_W), .FIFO_DEPTH(FIFO_DEPTH)) rct_top_i (
    .MCLK(MCLK), .RESET(RESET), .LINE_TX_CLK(LINE_TX_CLK), .TXD(TXD), .TX_WORD(TX_WORD),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RXD(RXD), .RX_CLK(RX_CLK), .RX_BIT(RX_BIT),
    .RX_BIT_VALID(RX_BIT_VALID));
  rct_mux_model rct_mux_model_i (
    .stall(stall), .capture(capture), .TXD(TXD), .LINE_TX_CLK(LINE_TX_CLK), .RXD(RXD));

  initial MCLK = 1'h0;
  always #12.5 MCLK = ~MCLK;
  always @(posedge MCLK) if (RX_BIT_VALID === 1'h1) rx_seen.push_back(RX_BIT);
  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic has_seq(input logic q[$], input logic p[$]);
    logic ok;
    for (int s = 0; s + p.size() <= q.size(); s++) begin
      ok = 1'h1;
      for (int k = 0; k < p.size(); k++) if (q[s+k] !== p[k]) ok = 1'h0;
      if (ok) return 1'h1;
    end
    return 1'h0;
  endfunction
  function automatic logic [WORD_W-1:0] word_of(input int i);
    return {i[3:0], ~i[3:0]};
  endfunction
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    RESET <= 1'h1;
    // Long enough for the link domain to see several falling edges
    repeat (30) @(posedge MCLK);
    @(negedge MCLK);
    check("ready_in_reset", TX_READY, 0);
    check("rx_clk_in_reset", RX_CLK, 0);
    check("rx_valid_in_reset", RX_BIT_VALID, 0);
    check("txd_idle_in_reset", TXD, 1);
    @(posedge MCLK);
    RESET <= 1'h0;
    @(posedge MCLK);
    @(negedge MCLK);
    check("ready_after_reset", TX_READY, 1);
  endtask
  task automatic t_tx_fill();
    int                n;
    int                idle;
    int                gap_err;
    logic              took;
    logic [WORD_W-1:0] w;
    logic              exp[$];
    n = 0;
    idle = 0;
    gap_err = 0;
    took = 1'h0;
    stall <= 1'h1;
    repeat (20) @(posedge MCLK);
    TX_WORD <= word_of(0);
    TX_VALID <= 1'h1;
    while (idle < 40 && n < 40) begin
      @(posedge MCLK);
      if (took && TX_READY === 1'h1) gap_err++;
      took = (TX_READY === 1'h1);
      if (took) begin
        n++;
        idle = 0;
        TX_WORD <= word_of(n);
      end else idle++;
    end
    TX_VALID <= 1'h0;
    check("tx_back_to_back_take", gap_err, 0);
    check("tx_fill_count", (n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1), 1);
    capture <= 1'h1;
    stall <= 1'h0;
    repeat (2500) @(posedge MCLK);
    capture <= 1'h0;
    @(posedge MCLK);
    for (int i = 0; i <= n; i++) begin
      w = (i < n) ? word_of(i) : IDLE_WORD;
      for (int b = WORD_W - 1; b >= 0; b--) exp.push_back(w[b]);
    end
    check("tx_stream_msb_first", has_seq(rct_mux_model_i.tx_bits, exp), 1);
    check("tx_ready_after_drain", TX_READY, 1);
  endtask
  task automatic t_rx_burst(input logic [15:0] pat);
    logic exp[$];
    int   gap;
    int   rises;
    logic prev_clk;
    rx_seen.delete();
    repeat (12) rct_mux_model_i.rx_bits.push_back(1'h1);
    for (int b = 15; b >= 0; b--) begin
      rct_mux_model_i.rx_bits.push_back(pat[b]);
      exp.push_back(pat[b]);
    end
    repeat (4) rct_mux_model_i.rx_bits.push_back(1'h0);
    repeat (8 * 625) @(posedge MCLK);
    gap = 0;
    rises = 0;
    while (RX_BIT_VALID !== 1'h1 && gap < 800) begin
      @(posedge MCLK);
      gap++;
    end
    @(posedge MCLK);
    check("rx_valid_one_cycle", RX_BIT_VALID, 0);
    gap = 1;
    prev_clk = RX_CLK;
    while (RX_BIT_VALID !== 1'h1 && gap < 800) begin
      @(posedge MCLK);
      gap++;
      if (RX_CLK === 1'h1 && prev_clk === 1'h0) rises++;
      prev_clk = RX_CLK;
    end
    check("rx_bit_spacing", (gap >= 580 && gap <= 690), 1);
    check("rx_clk_rises_per_bit", rises, 1);
    repeat (28 * 625) @(posedge MCLK);
    check("rx_nrzi_decode", has_seq(rx_seen, exp), 1);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    RESET = 1'h1;
    TX_VALID = 1'h0;
    TX_WORD = '0;
    stall = 1'h0;
    capture = 1'h0;
    n_mismatch = 0;
    total_checks = 0;
    t_reset();
    t_tx_fill();
    // Odd count of marks here, so the second burst starts from the other line level
    t_rx_burst(16'hB2E5);
    t_reset();
    t_rx_burst(16'h4D1A);
    give_verdict();
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
